// ---- design/spr_defines.vh ----
`ifndef SPR_DEFINES_VH
`define SPR_DEFINES_VH

// ****************************************************************
// Register selection codes (three bits, eight registers).
// ****************************************************************
`define SPR_SEL_W          3
`define SPR_REG_DATA       3'h0
`define SPR_REG_INPUT      3'h1

// ****************************************************************
// Link frame layout: positions counted in link clock rising edges.
// ****************************************************************
`define SPR_IDX_W          4
`define SPR_IDX_KIND       4'h1
`define SPR_IDX_DIR        4'h2
`define SPR_IDX_TURN       4'h3
`define SPR_IDX_LASTBIT    4'hb
`define SPR_IDX_END        4'hc

// ****************************************************************
// Field positions of the input status byte.
// ****************************************************************
`define SPR_IN_MODE_BIT    7
`define SPR_IN_EXT_HI      6
`define SPR_IN_EXT_LO      4
`define SPR_IN_SIZEOK_BIT  3
`define SPR_IN_GP_HI       2

// ****************************************************************
// Reset values of the descriptor bytes.
// ****************************************************************
`define SPR_RST_TYPE       3'h0
`define SPR_RST_COUNT      2'h0
`define SPR_RST_SIZE       3'h1
`define SPR_RST_EXT        3'h0

// ****************************************************************
// Peripheral bus cycle lengths in reference clock cycles.
// ****************************************************************
`define SPR_CNT_W          4
`define SPR_RD_CYC         4'h4
`define SPR_WR_CYC         4'h3

// ****************************************************************
// Mode strap capture point, in edges after reset release.
// ****************************************************************
`define SPR_STRAP_EDGE     2'h2

`endif

// ---- design/spr_sync.v ----
`default_nettype none

// ****************************************************************
// Two flip-flop synchroniser, one stage pair per bit.
// ****************************************************************
module spr_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             rstN,
  // Asynchronous inputs and their synchronised copies.
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  genvar i;

  // Each bit has its own pair; the first stage feeds only the second.
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      reg meta_q;   // First stage, may go metastable.
      reg stab_q;   // Second stage, safe to read.
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= asyncIn[i];
          stab_q <= meta_q;
        end
      end
      assign syncOut[i] = stab_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- design/spr_info_regs.v ----
// Behaviour
// - Link frames are control or data bytes.
// - Control selects register; data moves register values.
// - Eight registers selectable by the host.
// - Peripheral data lines undriven except write cycles.
// - Write cycle drives last register 0 value.
// - Read cycle captures bus for register 0 read.
// - Register 0 holds descriptor byte after reset.
// - Type field encoding passed through as configured.
// - Size field encoding passed through as configured.
// - Register 1 reads return input status only.
// - Status byte: mode, extended type, size, inputs.
// - Extended type bits hold configured extended descriptor.
// - General input bits follow their input pins.
// - Size-check bit follows pin, low when mode clear.
`include "spr_defines.vh"
`default_nettype none

module spr_info_regs #(
  parameter [2:0] DEV_TYPE  = `SPR_RST_TYPE,
  parameter [1:0] DEV_COUNT = `SPR_RST_COUNT,
  parameter [2:0] DEV_SIZE  = `SPR_RST_SIZE,
  parameter [2:0] EXT_KIND  = `SPR_RST_EXT
) (
  // Clock and reset.
  input  wire       ref_clk,
  input  wire       rst_n,
  // Serial link pins.
  input  wire       linkClk,
  input  wire       linkDataIn,
  output reg        linkDataOut,
  output reg        linkDataOe,
  output wire       linkBusy,
  // Peripheral data bus and strobes.
  input  wire [7:0] periphDataIn,
  output reg  [7:0] periphDataOut,
  output reg        periphDataOe,
  output wire       periphRdN,
  output wire       periphWrN,
  // Strap and sense inputs.
  input  wire       modeStrap,
  input  wire       sizeOkPin,
  input  wire [2:0] gpSensePins
);

  // ****************************************************************
  // Reset release and input synchronisation.
  // ****************************************************************

  reg         rstMeta_q;   // First stage of reset release.
  reg         rstN_q;      // Released reset used by all logic.
  wire [14:0] syncBits;    // Synchronised pin levels.

  // Reset asserts at once and releases after two clock edges.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstN_q    <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q    <= rstMeta_q;
    end
  end

  // All pins come from outside the clock domain.
  spr_sync #(
    .WIDTH   (15)
  ) uSync (
    .clk     (ref_clk),
    .rstN    (rstN_q),
    .asyncIn ({linkClk, linkDataIn, modeStrap, sizeOkPin,
               gpSensePins, periphDataIn}),
    .syncOut (syncBits)
  );

  wire       linkClkS  = syncBits[14];   // Link clock level.
  wire       linkDatS  = syncBits[13];   // Link data level.
  wire       modeS     = syncBits[12];   // Mode strap level.
  wire       sizeOkS   = syncBits[11];   // Size-check pin level.
  wire [2:0] gpS       = syncBits[10:8]; // General input levels.
  wire [7:0] periphS   = syncBits[7:0];  // Peripheral bus levels.

  // ****************************************************************
  // State.
  // ****************************************************************

  reg                    clkPrev_q;   // Link clock one cycle ago.
  reg  [1:0]             strapCnt_q;  // Edges since reset release.
  reg                    modeFlag_q;  // Mode flag caught after reset.
  reg                    active_q;    // A frame is in progress.
  reg  [`SPR_IDX_W-1:0]  idx_q;       // Position within the frame.
  reg                    kindData_q;  // High for a data frame.
  reg                    dirOut_q;    // High when device sends.
  reg  [7:0]             shift_q;     // Frame byte shifter.
  reg  [`SPR_SEL_W-1:0]  regSel_q;    // Register chosen by control.
  reg  [7:0]             dataReg_q;   // Register 0 contents.
  reg  [2:0]             extKind_q;   // Extended descriptor.
  reg                    infoPend_q;  // Descriptor not yet read.
  reg  [`SPR_CNT_W-1:0]  rdCnt_q;     // Read cycle countdown.
  reg  [`SPR_CNT_W-1:0]  wrCnt_q;     // Write cycle countdown.

  // Edge of the link clock as seen after synchronisation.
  wire linkRise = linkClkS & ~clkPrev_q;

  // Input status byte, built from the caught mode flag, the extended descriptor and live pins.
  wire [7:0] inputStatus;
  assign inputStatus[`SPR_IN_MODE_BIT] = modeFlag_q;
  assign inputStatus[`SPR_IN_EXT_HI:`SPR_IN_EXT_LO] = extKind_q;
  // Size-check reads low whenever the mode flag is clear.
  assign inputStatus[`SPR_IN_SIZEOK_BIT] = sizeOkS & modeFlag_q;
  assign inputStatus[`SPR_IN_GP_HI:0] = gpS;

  // Value loaded for a device-to-host byte, other than a bus read.
  reg [7:0] readMux;

  // Registers other than 0 and 1 are unimplemented and read zero.
  always @* begin
    case (regSel_q)
      `SPR_REG_DATA:  readMux = dataReg_q;
      `SPR_REG_INPUT: readMux = inputStatus;
      default:        readMux = 8'h00;
    endcase
  end

  // Strobes come straight from the countdowns.
  assign periphRdN = (rdCnt_q == 4'h0);
  assign periphWrN = !((wrCnt_q > 4'h1) &&
                       (wrCnt_q < `SPR_WR_CYC + 4'h2));
  // Busy covers the frame and any bus cycle it started.
  assign linkBusy  = active_q | (rdCnt_q != 4'h0) |
                     (wrCnt_q != 4'h0);

  // ****************************************************************
  // Mode strap capture.
  // ****************************************************************

  // The strap is caught once, after its synchroniser has refilled
  // from reset, so the flag never takes the cleared stage value and
  // never follows later movement of the pin.
  always @(posedge ref_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      strapCnt_q <= 2'h0;
      modeFlag_q <= 1'b0;
    end else if (strapCnt_q != 2'h3) begin
      strapCnt_q <= strapCnt_q + 2'h1;
      if (strapCnt_q == `SPR_STRAP_EDGE) begin
        modeFlag_q <= modeS;
      end
    end
  end

  // ****************************************************************
  // Frame engine and peripheral bus cycles.
  // ****************************************************************

  // One process owns the shifter, since both the link and a bus read
  // load it; a read always completes before the turnaround edge.
  always @(posedge ref_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      clkPrev_q     <= 1'b0;
      active_q      <= 1'b0;
      idx_q         <= 4'h0;
      kindData_q    <= 1'b0;
      dirOut_q      <= 1'b0;
      shift_q       <= 8'h00;
      regSel_q      <= `SPR_REG_DATA;
      dataReg_q     <= {DEV_TYPE, DEV_COUNT, DEV_SIZE};
      extKind_q     <= EXT_KIND;
      infoPend_q    <= 1'b1;
      rdCnt_q       <= 4'h0;
      wrCnt_q       <= 4'h0;
      linkDataOut   <= 1'b0;
      linkDataOe    <= 1'b0;
      periphDataOut <= 8'h00;
      periphDataOe  <= 1'b0;
    end else begin
      clkPrev_q <= linkClkS;
      // Read cycle: capture the bus on its last strobe cycle.
      if (rdCnt_q != 4'h0) begin
        rdCnt_q <= rdCnt_q - 4'h1;
        if (rdCnt_q == 4'h1) begin
          shift_q <= periphS;
        end
      end
      // Write cycle: drive the bus only while the countdown runs.
      if (wrCnt_q != 4'h0) begin
        wrCnt_q <= wrCnt_q - 4'h1;
        if (wrCnt_q == 4'h1) begin
          periphDataOe <= 1'b0;
        end
      end
      if (linkRise) begin
        if (!active_q) begin
          // A high level on an idle line starts a frame.
          if (linkDatS) begin
            active_q <= 1'b1;
            idx_q    <= `SPR_IDX_KIND;
          end
        end else begin
          idx_q <= idx_q + 4'h1;
          case (idx_q)
            `SPR_IDX_KIND: begin
              kindData_q <= linkDatS;
            end
            `SPR_IDX_DIR: begin
              // Control bytes only travel host to device.
              dirOut_q <= linkDatS & kindData_q;
              if (linkDatS && kindData_q) begin
                if (regSel_q == `SPR_REG_DATA && !infoPend_q) begin
                  rdCnt_q <= `SPR_RD_CYC;
                end else begin
                  shift_q <= readMux;
                  if (regSel_q == `SPR_REG_DATA) begin
                    infoPend_q <= 1'b0;
                  end
                end
              end
            end
            `SPR_IDX_END: begin
              active_q   <= 1'b0;
              linkDataOe <= 1'b0;
              if (!kindData_q) begin
                regSel_q <= shift_q[`SPR_SEL_W-1:0];
              end else if (!dirOut_q &&
                           regSel_q == `SPR_REG_DATA) begin
                // Writes to register 1 and above change nothing here.
                dataReg_q     <= shift_q;
                infoPend_q    <= 1'b0;
                periphDataOut <= shift_q;
                periphDataOe  <= 1'b1;
                wrCnt_q       <= `SPR_WR_CYC + 4'h2;
              end
            end
            default: begin
              if (dirOut_q) begin
                // Send from the turnaround edge; host samples a beat
                // later, leaving time for the bus read.
                if (idx_q < `SPR_IDX_LASTBIT) begin
                  linkDataOe  <= 1'b1;
                  linkDataOut <= shift_q[7];
                  shift_q     <= {shift_q[6:0], 1'b0};
                end
              end else if (idx_q != `SPR_IDX_TURN) begin
                shift_q <= {shift_q[6:0], linkDatS};
              end
            end
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- verification/spr_info_regs_checker.sv ----
`default_nettype none
module spr_info_regs_checker (
  // Clock and reset.
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Link status.
  input wire logic       linkDataOe,
  input wire logic       linkBusy,
  // Peripheral bus.
  input wire logic [7:0] periphDataOut,
  input wire logic       periphDataOe,
  input wire logic       periphRdN,
  input wire logic       periphWrN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Peripheral bus cycles.
  // ****************************************************************
  rd_undriven_a: assert property (!periphRdN |-> !periphDataOe)
    else $error("Bus driven during a read strobe.");
  wr_driven_a: assert property (!periphWrN |-> periphDataOe)
    else $error("Bus not driven during a write strobe.");
  wr_setup_a: assert property ($fell(periphWrN) |-> $past(periphDataOe))
    else $error("Write strobe without data set up first.");
  wr_stable_a: assert property (!periphWrN |-> $stable(periphDataOut))
    else $error("Write data moved under the strobe.");
  rd_length_a: assert property (
    $fell(periphRdN) |-> !periphRdN [*4] ##1 periphRdN)
    else $error("Read strobe length wrong.");
  wr_length_a: assert property (
    $fell(periphWrN) |-> !periphWrN [*3] ##1 periphWrN)
    else $error("Write strobe length wrong.");
  oe_release_a: assert property ($fell(periphDataOe) |-> periphWrN)
    else $error("Bus released while write strobe low.");
  // ****************************************************************
  // Link status.
  // ****************************************************************
  bus_busy_a: assert property (!(periphRdN && periphWrN) |-> linkBusy)
    else $error("Link not busy during a bus cycle.");
  link_oe_busy_a: assert property (linkDataOe |-> linkBusy)
    else $error("Device drives link outside a frame.");
  // Main scenarios reached.
  cover property ($fell(periphWrN));
  cover property ($fell(periphRdN));
  cover property ($rose(linkDataOe));
endmodule
bind spr_info_regs spr_info_regs_checker chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .linkDataOe(linkDataOe),
  .linkBusy(linkBusy), .periphDataOut(periphDataOut),
  .periphDataOe(periphDataOe), .periphRdN(periphRdN),
  .periphWrN(periphWrN));
`default_nettype wire

// ---- verification/spr_host_model.sv ----
`default_nettype none
module spr_host_model (
  // Reference clock, used only to time the result strobe.
  input  wire logic       refClk,
  // Link as seen by the host.
  output var  logic       linkClk,
  output var  logic       hostData,
  input  wire logic       linkLine,
  input  wire logic       linkBusy,
  // Byte received by a read frame and its one-cycle strobe.
  output var  logic [7:0] rdByte,
  output var  logic       rdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  // The link clock stands low between frames.
  initial begin
    linkClk = 1'b0;
    hostData = 1'b0;
    rdByte = 8'h00;
    rdValid = 1'b0;
  end
  // One frame: start, kind, direction, turnaround, byte MSB first, end.
  task automatic xfer(input logic kind, input logic dir, input logic [7:0] b);
    logic [12:0] bits;
    bits = {1'b1, kind, dir, 1'b0, b, 1'b0};
    wait (linkBusy === 1'b0);
    #203;
    for (int i = 0; i < 13; i++) begin
      // While the device answers, a changing level exposes a late driver.
      hostData = (dir && i > 3 && i < 12) ? ~hostData : bits[12-i];
      #80 linkClk = 1'b1;
      if (dir && i > 3 && i < 12)
        rdByte[11-i] = linkLine;
      #80 linkClk = 1'b0;
    end
    hostData = 1'b0;
    if (dir) begin
      @(posedge refClk) #1 rdValid = 1'b1;
      @(posedge refClk) #1 rdValid = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/serial_peripheral_info_registers_tb_top.sv ----
`default_nettype none
module serial_peripheral_info_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus state and shared wires.
  // ****************************************************************
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        modeStrap = 1'b1;
  logic        sizeOkPin = 1'b0;
  logic [2:0]  gpSensePins = 3'h0;
  logic [7:0]  busVal = 8'h00;   // Level the peripheral returns.
  logic [31:0] rnd = 32'h4425;
  logic [7:0]  expQ[$];          // Expected results, oldest first.
  logic        wrPrev = 1'b1;
  int          failures = 0;
  int          checks_done = 0;
  wire         linkClk, hostData, linkDataOut, linkDataOe, linkBusy;
  wire         linkLine, rdValid, periphDataOe, periphRdN, periphWrN;
  wire  [7:0]  rdByte, periphDataOut, periphDataIn;
  // The device wins the link line while its enable is high.
  assign linkLine = linkDataOe ? linkDataOut : hostData;
  // Undriven and outside a read strobe, the bus shows the inverse level.
  assign periphDataIn = periphDataOe ? periphDataOut :
                        (periphRdN ? ~busVal : busVal);
  always #10 ref_clk = ~ref_clk;
  // The size field keeps its default code, the smallest legal size.
  spr_info_regs #(.DEV_TYPE(3'h5), .DEV_COUNT(2'h3),
                  .EXT_KIND(3'h6)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .linkClk(linkClk),
    .linkDataIn(linkLine), .linkDataOut(linkDataOut),
    .linkDataOe(linkDataOe), .linkBusy(linkBusy),
    .periphDataIn(periphDataIn), .periphDataOut(periphDataOut),
    .periphDataOe(periphDataOe), .periphRdN(periphRdN),
    .periphWrN(periphWrN), .modeStrap(modeStrap),
    .sizeOkPin(sizeOkPin), .gpSensePins(gpSensePins));
  spr_host_model host_u (
    .refClk(ref_clk), .linkClk(linkClk), .hostData(hostData),
    .linkLine(linkLine), .linkBusy(linkBusy), .rdByte(rdByte),
    .rdValid(rdValid));
  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] nextRnd(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // An empty queue yields unknowns, so a surplus result fails.
  function automatic logic [7:0] takeNote();
    if (expQ.size() == 0)
      return 8'hxx;
    return expQ.pop_front();
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d.", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Select a register by control frame, then move one data byte.
  task automatic access(input logic [2:0] sel, input logic dir,
                        input logic [7:0] b);
    host_u.xfer(1'b0, 1'b0, {5'h00, sel});
    host_u.xfer(1'b1, dir, b);
  endtask
  // Each read result or write strobe consumes the oldest note.
  always @(posedge ref_clk) begin
    if (rdValid === 1'b1)
      check(rdByte, takeNote());
    else if (wrPrev === 1'b1 && periphWrN === 1'b0)
      check(periphDataOut, takeNote());
    wrPrev <= periphWrN;
  end
  // ****************************************************************
  // Main sequence, once with the mode flag set and once clear.
  // ****************************************************************
  initial begin
    for (int m = 1; m >= 0; m--) begin
      @(posedge ref_clk) #1 rst_n = 1'b0;
      modeStrap = m[0];
      repeat (6) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (8) @(posedge ref_clk);
      expQ.push_back(8'hb9);
      access(3'h0, 1'b1, 8'h00);
      for (int k = 0; k < 3; k++) begin
        rnd = nextRnd(rnd);
        @(posedge ref_clk) #1 {sizeOkPin, gpSensePins} = rnd[3:0];
        expQ.push_back({m[0], 3'h6, rnd[3] & m[0], rnd[2:0]});
        access(3'h1, 1'b1, 8'h00);
      end
      expQ.push_back(rnd[15:8]);
      access(3'h0, 1'b0, rnd[15:8]);
      access(3'h1, 1'b0, ~rnd[15:8]);
      expQ.push_back({m[0], 3'h6, rnd[3] & m[0], rnd[2:0]});
      access(3'h1, 1'b1, 8'h00);
      @(posedge ref_clk) #1 busVal = rnd[23:16];
      expQ.push_back(rnd[23:16]);
      access(3'h0, 1'b1, 8'h00);
      for (int r = 2; r < 8; r++) begin
        expQ.push_back(8'h00);
        access(r[2:0], 1'b1, 8'h00);
      end
      $display("Pass with mode flag %0d finished.", m);
    end
    repeat (20) @(posedge ref_clk);
    // A note left over means an expected result never appeared.
    check(8'(expQ.size()), 8'h00);
    end_of_test();
  end
  // A hung handshake ends the run well past the expected 130 us.
  initial begin
    #500000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
